/* mipc_params.svh */
// Constants for the interrupt priority controller: offsets, bit positions, vectors.
// Assumes inclusion by bare name from the package and the bench.
`ifndef MIPC_PARAMS_SVH
`define MIPC_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MIPC_OFS_SYSOPT     8'h0C
`define MIPC_OFS_SERCTL2    8'h0F
`define MIPC_OFS_SERSTAT    8'h10
`define MIPC_OFS_TMRCTL     8'h12
`define MIPC_OFS_TMRSTAT    8'h13
`define MIPC_OFS_CPUSTAT    8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MIPC_BIT_POL        6
`define MIPC_BIT_NEG        5
`define MIPC_BIT_ENA        4
`define MIPC_SYSOPT_RST     8'h10

// ----------------------------------------
// Vectors (high byte address)
// ----------------------------------------
`define MIPC_VEC_RESET      16'h1FFE
`define MIPC_VEC_TRAP       16'h1FFC
`define MIPC_VEC_EXT        16'h1FFA
`define MIPC_VEC_CAPT       16'h1FF8
`define MIPC_VEC_CMP        16'h1FF6
`define MIPC_VEC_OVF        16'h1FF4
`define MIPC_VEC_SER        16'h1FF2

`endif

/* mipc_pkg.sv */
// Types for the interrupt priority controller.
// Assumes mipc_params.svh is on the include path.
package mipc_pkg;
    `include "mipc_params.svh"

    // ----------------------------------------
    // Interrupt sources, highest first
    // ----------------------------------------
    typedef enum logic [2:0] {
        MIPC_SRC_NONE,
        MIPC_SRC_RESET,
        MIPC_SRC_TRAP,
        MIPC_SRC_EXT,
        MIPC_SRC_CAPT,
        MIPC_SRC_CMP,
        MIPC_SRC_OVF,
        MIPC_SRC_SER
    } mipc_src_t;

    // ----------------------------------------
    // Sleep state
    // ----------------------------------------
    typedef enum logic [1:0] {
        MIPC_RUN,
        MIPC_WAIT,
        MIPC_STOP
    } mipc_sleep_t;

    // ----------------------------------------
    // Grant to the core sequencer
    // ----------------------------------------
    typedef struct packed {
        logic        valid;
        mipc_src_t   src;
        logic [15:0] vec;
    } mipc_grant_t;
endpackage

/* mipc_ctrl.sv */
// Interrupt arbitration, external pin front end and sleep wake-up control.
// Assumes a core sequencer that flags instruction boundaries and a register port.
//
// What this block does
// - Software trap is taken regardless of the mask bit.
// - Trap follows hardware requests pending at its fetch, precedes later ones.
// - Trap vectors through 0x1FFC and 0x1FFD.
// - Priority: reset, trap, pin, captures, compares, overflow, serial at 0x1FF2.
// - Mask bit set holds off all maskable sources; clearing it releases them.
// - Pin request needs mask clear, enable set, activity matching sensitivity.
// - Pin service sets mask, vectors through 0x1FFA.
// - Pin enable, polarity, negative bits at 0x000C bits 4, 6, 5.
// - Sensitivity: 00 fall plus low, 01 fall, 10 rise, 11 both.
// - Sensitivity bits written only with mask set; cleared by reset.
// - Pin enable written only with mask set; set by reset.
// - Option writes with mask clear leave the bits unchanged.
// - Changing the pin sensitivity discards a pending pin request.
// - Edge seen while disabled stays latched until enabled.
// - Edge latch cleared early in service; low level never latched.
// - Five timer flags in upper bits of 0x0013, request when set and enabled.
// - Captures vector 0x1FF8, compares 0x1FF6, overflow 0x1FF4.
// - Three timer enables at 0x0012 gate capture, compare, overflow.
// - Serial flags upper bits of 0x0010, four enables at 0x000F.
// - Reset vectors through 0x1FFE/0x1FFF and sets the mask bit.
// - Stop waits for pin or reset; wait wakes on pin, timer, serial.
// - Requests other than reset wait for the instruction boundary.
//
// Our own choice: strobed register access.
module mipc_ctrl (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,
    // Core sequencer
    input  wire logic                 insn_done,
    input  wire logic                 trap_fetch,
    input  wire logic                 mask_set,
    input  wire logic                 mask_clr,
    input  wire logic                 stop_req,
    input  wire logic                 wait_req,
    output mipc_pkg::mipc_grant_t     grant,
    output logic                      mask_q,
    output logic                      osc_run,
    output logic                      cpu_clk_run,
    // Sources
    input  wire logic                 ext_pin,
    input  wire logic [4:0]           tmr_flags,
    input  wire logic [4:0]           ser_flags
);

    // ----------------------------------------
    // Pin synchroniser and edges
    // ----------------------------------------
    logic        pin_s1_q;
    logic        pin_s2_q;
    logic        pin_old_q;
    logic        ext_polarity_sel_q;
    logic        ext_negative_sel_q;
    logic        ext_int_enable_q;
    logic        ext_latch_q;
    logic [2:0]  timer_control_enables_q;
    logic [3:0]  serial_control_two_q;
    logic        trap_pend_q;
    logic        trap_hw_q;
    logic        reset_pend_q;
    mipc_pkg::mipc_sleep_t sleep_q;
    mipc_pkg::mipc_grant_t grant_d;

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_s1_q  <= 1'b1;
            pin_s2_q  <= 1'b1;
            pin_old_q <= 1'b1;
        end else begin
            pin_s1_q  <= ext_pin;
            pin_s2_q  <= pin_s1_q;
            pin_old_q <= pin_s2_q;
        end
    end

    wire fall_edge = pin_old_q & ~pin_s2_q;
    wire rise_edge = ~pin_old_q & pin_s2_q;
    wire edge_hit  = (ext_polarity_sel_q ? rise_edge : fall_edge)
                   | (ext_polarity_sel_q & ext_negative_sel_q & fall_edge);
    wire level_hit = ~ext_polarity_sel_q & ~ext_negative_sel_q & ~pin_s2_q;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    wire wr_sysopt  = reg_wr && reg_addr == `MIPC_OFS_SYSOPT;
    wire wr_serctl  = reg_wr && reg_addr == `MIPC_OFS_SERCTL2;
    wire wr_tmrctl  = reg_wr && reg_addr == `MIPC_OFS_TMRCTL;
    wire opt_write  = wr_sysopt && mask_q;
    wire opt_change = opt_write
                   && ({reg_wdata[`MIPC_BIT_POL], reg_wdata[`MIPC_BIT_NEG]}
                       != {ext_polarity_sel_q, ext_negative_sel_q});
    wire [7:0] sysopt_rd = {1'b0, ext_polarity_sel_q, ext_negative_sel_q, ext_int_enable_q, 4'h0};
    wire [7:0] rdata_d =
        reg_addr == `MIPC_OFS_SYSOPT  ? sysopt_rd :
        reg_addr == `MIPC_OFS_SERCTL2 ? {serial_control_two_q, 4'h0} :
        reg_addr == `MIPC_OFS_SERSTAT ? {ser_flags, 3'h0} :
        reg_addr == `MIPC_OFS_TMRCTL  ? {timer_control_enables_q, 5'h00} :
        reg_addr == `MIPC_OFS_TMRSTAT ? {tmr_flags, 3'h0} :
        reg_addr == `MIPC_OFS_CPUSTAT ? {4'h0, ext_latch_q, trap_pend_q, 1'b0, mask_q} :
        8'h00;

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata               <= 8'h00;
            ext_polarity_sel_q      <= 1'b0;
            ext_negative_sel_q      <= 1'b0;
            ext_int_enable_q        <= 1'b1;
            timer_control_enables_q <= 3'h0;
            serial_control_two_q    <= 4'h0;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
            if (opt_write) begin
                ext_polarity_sel_q <= reg_wdata[`MIPC_BIT_POL];
                ext_negative_sel_q <= reg_wdata[`MIPC_BIT_NEG];
                ext_int_enable_q   <= reg_wdata[`MIPC_BIT_ENA];
            end
            if (wr_tmrctl) timer_control_enables_q <= reg_wdata[7:5];
            if (wr_serctl) serial_control_two_q <= reg_wdata[7:4];
        end
    end

    // ----------------------------------------
    // Request qualification
    // ----------------------------------------
    wire ext_req  = ext_int_enable_q & (ext_latch_q | level_hit);
    wire capt_req = timer_control_enables_q[2] & (|tmr_flags[4:3]);
    wire cmp_req  = timer_control_enables_q[1] & (|tmr_flags[2:1]);
    wire ovf_req  = timer_control_enables_q[0] & tmr_flags[0];
    wire ser_req  = (serial_control_two_q[3] & ser_flags[4])
                  | (serial_control_two_q[2] & ser_flags[3])
                  | (serial_control_two_q[1] & (ser_flags[2] | ser_flags[1]))
                  | (serial_control_two_q[0] & ser_flags[0]);
    wire any_hw   = ext_req | capt_req | cmp_req | ovf_req | ser_req;
    wire hw_live  = ~mask_q & any_hw;
    // Trap yields only to hardware already pending at its fetch
    wire hw_first = hw_live & trap_hw_q;

    always_comb begin
        grant_d = '0;
        if (reset_pend_q) begin
            grant_d = '{1'b1, mipc_pkg::MIPC_SRC_RESET, `MIPC_VEC_RESET};
        end else if (insn_done && sleep_q == mipc_pkg::MIPC_RUN) begin
            if (trap_pend_q && !hw_first)
                grant_d = '{1'b1, mipc_pkg::MIPC_SRC_TRAP, `MIPC_VEC_TRAP};
            else if (hw_live && ext_req)
                grant_d = '{1'b1, mipc_pkg::MIPC_SRC_EXT, `MIPC_VEC_EXT};
            else if (hw_live && capt_req)
                grant_d = '{1'b1, mipc_pkg::MIPC_SRC_CAPT, `MIPC_VEC_CAPT};
            else if (hw_live && cmp_req)
                grant_d = '{1'b1, mipc_pkg::MIPC_SRC_CMP, `MIPC_VEC_CMP};
            else if (hw_live && ovf_req)
                grant_d = '{1'b1, mipc_pkg::MIPC_SRC_OVF, `MIPC_VEC_OVF};
            else if (hw_live && ser_req)
                grant_d = '{1'b1, mipc_pkg::MIPC_SRC_SER, `MIPC_VEC_SER};
        end
    end

    wire took_ext  = grant_d.valid && grant_d.src == mipc_pkg::MIPC_SRC_EXT;
    wire took_trap = grant_d.valid && grant_d.src == mipc_pkg::MIPC_SRC_TRAP;
    wire wake_stop = ext_req;
    wire wake_wait = ext_req | capt_req | cmp_req | ovf_req | ser_req;

    // ----------------------------------------
    // Latches, mask and sleep
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_latch_q  <= 1'b0;
            trap_pend_q  <= 1'b0;
            trap_hw_q    <= 1'b0;
            reset_pend_q <= 1'b1;
            mask_q       <= 1'b1;
            sleep_q      <= mipc_pkg::MIPC_RUN;
            grant        <= '0;
            osc_run      <= 1'b1;
            cpu_clk_run  <= 1'b1;
        end else begin
            grant        <= grant_d;
            reset_pend_q <= 1'b0;
            // Edge set wins over service clear; option change discards
            if (opt_change)
                ext_latch_q <= 1'b0;
            else if (edge_hit)
                ext_latch_q <= 1'b1;
            else if (took_ext)
                ext_latch_q <= 1'b0;
            if (trap_fetch) begin
                trap_pend_q <= 1'b1;
                trap_hw_q   <= any_hw;
            end else if (took_trap) begin
                trap_pend_q <= 1'b0;
            end
            if (grant_d.valid || mask_set)
                mask_q <= 1'b1;
            else if (mask_clr)
                mask_q <= 1'b0;
            case (sleep_q)
                mipc_pkg::MIPC_RUN: begin
                    if (stop_req) begin
                        sleep_q     <= mipc_pkg::MIPC_STOP;
                        mask_q      <= 1'b0;
                        osc_run     <= 1'b0;
                        cpu_clk_run <= 1'b0;
                    end else if (wait_req) begin
                        sleep_q     <= mipc_pkg::MIPC_WAIT;
                        mask_q      <= 1'b0;
                        cpu_clk_run <= 1'b0;
                    end
                end
                mipc_pkg::MIPC_WAIT: begin
                    if (wake_wait) begin
                        sleep_q     <= mipc_pkg::MIPC_RUN;
                        cpu_clk_run <= 1'b1;
                    end
                end
                mipc_pkg::MIPC_STOP: begin
                    if (wake_stop) begin
                        sleep_q     <= mipc_pkg::MIPC_RUN;
                        osc_run     <= 1'b1;
                        cpu_clk_run <= 1'b1;
                    end
                end
                default: sleep_q <= mipc_pkg::MIPC_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Instruction boundary while awake; reset grant has already gone
    sequence s_boundary;
        insn_done && sleep_q == mipc_pkg::MIPC_RUN && !reset_pend_q;
    endsequence

    sequence s_open;
        s_boundary ##0 (!trap_pend_q && !mask_q);
    endsequence

    sequence s_boundary_hw;
        insn_done && sleep_q == mipc_pkg::MIPC_RUN && !reset_pend_q && !trap_pend_q && !mask_q && ext_req;
    endsequence

    chk_ext_grant_vec: assert property (@(posedge clk) disable iff (srst)
        s_boundary_hw |=> grant.valid && grant.vec == `MIPC_VEC_EXT && mask_q)
        else $error("pin grant wrong");
    chk_mask_blocks_hw: assert property (@(posedge clk) disable iff (srst)
        grant.valid && grant.src > mipc_pkg::MIPC_SRC_TRAP |-> $past(!mask_q))
        else $error("masked source granted");
    chk_trap_unmaskable: assert property (@(posedge clk) disable iff (srst)
        insn_done && sleep_q == mipc_pkg::MIPC_RUN && !reset_pend_q && trap_pend_q && mask_q
        |=> grant.valid && grant.vec == `MIPC_VEC_TRAP)
        else $error("trap not taken");
    chk_opt_locked: assert property (@(posedge clk) disable iff (srst)
        wr_sysopt && !mask_q |=> $stable({ext_polarity_sel_q, ext_negative_sel_q, ext_int_enable_q}))
        else $error("option changed while unmasked");
    chk_opt_discard: assert property (@(posedge clk) disable iff (srst)
        opt_change |=> !ext_latch_q)
        else $error("pending pin kept");
    chk_no_boundary: assert property (@(posedge clk) disable iff (srst)
        !insn_done && !reset_pend_q |=> !grant.valid)
        else $error("grant mid instruction");
    chk_wait_wake: assert property (@(posedge clk) disable iff (srst)
        sleep_q == mipc_pkg::MIPC_WAIT && ovf_req |=> sleep_q == mipc_pkg::MIPC_RUN ##0 cpu_clk_run)
        else $error("wait missed timer wake");
    chk_stop_hold: assert property (@(posedge clk) disable iff (srst)
        sleep_q == mipc_pkg::MIPC_STOP && !ext_req |=> sleep_q == mipc_pkg::MIPC_STOP && !osc_run)
        else $error("stop left early");
    chk_ovf_vec: assert property (@(posedge clk) disable iff (srst)
        grant.valid && grant.src == mipc_pkg::MIPC_SRC_OVF |-> grant.vec == `MIPC_VEC_OVF)
        else $error("overflow vector wrong");

    chk_reset_vec: assert property (
        reset_pend_q |=> grant.valid && grant.src == mipc_pkg::MIPC_SRC_RESET && grant.vec == `MIPC_VEC_RESET)
        else $error("reset grant wrong");

    chk_reset_mask: assert property (
        reset_pend_q |-> mask_q)
        else $error("mask clear after reset");

    chk_trap_vec: assert property (
        grant.valid && grant.src == mipc_pkg::MIPC_SRC_TRAP |-> grant.vec == `MIPC_VEC_TRAP)
        else $error("trap vector wrong");

    chk_ext_vec: assert property (
        grant.valid && grant.src == mipc_pkg::MIPC_SRC_EXT |-> grant.vec == `MIPC_VEC_EXT)
        else $error("pin vector wrong");

    chk_capt_vec: assert property (
        grant.valid && grant.src == mipc_pkg::MIPC_SRC_CAPT |-> grant.vec == `MIPC_VEC_CAPT)
        else $error("capture vector wrong");

    chk_ser_vec: assert property (
        grant.valid && grant.src == mipc_pkg::MIPC_SRC_SER |-> grant.vec == `MIPC_VEC_SER)
        else $error("serial vector wrong");

    chk_grant_masks: assert property (
        grant.valid && sleep_q == mipc_pkg::MIPC_RUN |-> mask_q)
        else $error("mask not set on grant");

    chk_capt_pick: assert property (
        s_open ##0 (!ext_req && capt_req) |=> grant.src == mipc_pkg::MIPC_SRC_CAPT)
        else $error("capture not chosen");

    chk_cmp_pick: assert property (
        s_open ##0 (!ext_req && !capt_req && cmp_req) |=> grant.src == mipc_pkg::MIPC_SRC_CMP)
        else $error("compare not chosen");

    chk_ovf_pick: assert property (
        s_open ##0 (!ext_req && !capt_req && !cmp_req && ovf_req) |=> grant.src == mipc_pkg::MIPC_SRC_OVF)
        else $error("overflow not chosen");

    chk_ser_pick: assert property (
        s_open ##0 (ser_req && !ext_req && !capt_req && !cmp_req && !ovf_req)
        |=> grant.src == mipc_pkg::MIPC_SRC_SER)
        else $error("serial not chosen");

    chk_no_mask_hw: assert property (
        s_boundary ##0 (mask_q && !trap_pend_q) |=> !grant.valid)
        else $error("grant while masked");

    chk_trap_first: assert property (
        s_boundary ##0 (trap_pend_q && !trap_hw_q) |=> grant.src == mipc_pkg::MIPC_SRC_TRAP)
        else $error("trap passed over");

    chk_trap_after_hw: assert property (
        s_boundary ##0 (trap_pend_q && trap_hw_q && hw_live)
        |=> grant.valid && grant.src != mipc_pkg::MIPC_SRC_TRAP)
        else $error("trap jumped older request");

    chk_sleep_no_grant: assert property (
        sleep_q != mipc_pkg::MIPC_RUN && !reset_pend_q |=> !grant.valid)
        else $error("grant while asleep");

    chk_stop_wake: assert property (
        sleep_q == mipc_pkg::MIPC_STOP && ext_req |=> sleep_q == mipc_pkg::MIPC_RUN && osc_run && cpu_clk_run)
        else $error("stop missed pin wake");

    chk_wait_hold: assert property (
        sleep_q == mipc_pkg::MIPC_WAIT && !wake_wait |=> sleep_q == mipc_pkg::MIPC_WAIT && !cpu_clk_run && osc_run)
        else $error("wait left early");

    chk_opt_write: assert property (
        opt_write |=> {ext_polarity_sel_q, ext_negative_sel_q, ext_int_enable_q}
                      == $past(reg_wdata[`MIPC_BIT_POL:`MIPC_BIT_ENA]))
        else $error("option write lost");

    chk_edge_latch: assert property (
        edge_hit && !opt_change |=> ext_latch_q)
        else $error("pin edge not latched");

    chk_latch_hold: assert property (
        ext_latch_q && !ext_int_enable_q && !opt_change |=> ext_latch_q)
        else $error("disabled latch dropped");

    chk_latch_clear: assert property (
        took_ext && !edge_hit |=> !ext_latch_q)
        else $error("latch kept after service");

    chk_level_free: assert property (
        !ext_latch_q && !edge_hit |=> !ext_latch_q)
        else $error("level latched");

    chk_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read");

    chk_tmr_read: assert property (
        reg_rd && reg_addr == `MIPC_OFS_TMRSTAT |=> reg_rdata == {$past(tmr_flags), 3'h0})
        else $error("timer flags read wrong");

    chk_ser_read: assert property (
        reg_rd && reg_addr == `MIPC_OFS_SERSTAT |=> reg_rdata == {$past(ser_flags), 3'h0})
        else $error("serial flags read wrong");

endmodule

/* mipc_core_model.sv */
// Partner model: core sequencer pacing the instruction boundaries.
// Assumes one clock shared with the controller; slow stretches instructions.
module mipc_core_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Pace select
    input  wire logic slow,
    // Boundary out
    output logic      insn_done
);
    // ----------------------------------------
    // Boundary pacing
    // ----------------------------------------
    logic [2:0] cnt_q;

    // Short and long instructions, so requests must wait either way
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q     <= 3'h0;
            insn_done <= 1'b0;
        end else begin
            cnt_q     <= (cnt_q == (slow ? 3'h4 : 3'h1)) ? 3'h0 : cnt_q + 3'h1;
            insn_done <= (cnt_q == 3'h0);
        end
    end
endmodule

/* mipc_ctrl_bench.sv */
// Self-checking bench for the interrupt priority controller.
// Assumes mipc_pkg compiled first and mipc_params.svh on the include path.
`include "mipc_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module mipc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk = 1'b0;
    logic                  srst = 1'b1;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic                  trap_fetch = 1'b0;
    logic                  mask_set = 1'b0;
    logic                  mask_clr = 1'b0;
    logic                  stop_req = 1'b0;
    logic                  wait_req = 1'b0;
    logic                  ext_pin = 1'b1;
    logic                  slow = 1'b0;
    logic [7:0]            reg_addr = 8'h00;
    logic [7:0]            reg_wdata = 8'h00;
    logic [7:0]            reg_rdata;
    logic [4:0]            tmr_flags = 5'h00;
    logic [4:0]            ser_flags = 5'h00;
    logic                  insn_done;
    logic                  mask_q;
    logic                  osc_run;
    logic                  cpu_clk_run;
    mipc_pkg::mipc_grant_t grant;
    mipc_pkg::mipc_grant_t gq [$];
    int                    fails = 0;
    int                    cmp_count = 0;
    int                    cyc = 0;

    mipc_ctrl u_mipc_ctrl (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .insn_done(insn_done), .trap_fetch(trap_fetch),
        .mask_set(mask_set), .mask_clr(mask_clr), .stop_req(stop_req), .wait_req(wait_req), .grant(grant),
        .mask_q(mask_q), .osc_run(osc_run), .cpu_clk_run(cpu_clk_run), .ext_pin(ext_pin),
        .tmr_flags(tmr_flags), .ser_flags(ser_flags));
    mipc_core_model u_mipc_core_model (.clk(clk), .srst(srst), .slow(slow), .insn_done(insn_done));

    always #20 clk = ~clk;
    // Grants stand one cycle, so collect them all
    always @(posedge clk) begin
        #1;
        if (grant.valid === 1'b1) gq.push_back(grant);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task results;
        $display("checks %0d fails %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #2 `CHK("rdata", e, reg_rdata);
    endtask
    // One-hot: 0 clear mask, 1 set mask, 2 trap, 3 wait, 4 stop
    task pulse(input int w);
        @(posedge clk);
        {mask_clr, mask_set, trap_fetch, wait_req, stop_req} <= 5'h10 >> w;
        @(posedge clk);
        {mask_clr, mask_set, trap_fetch, wait_req, stop_req} <= 5'h00;
    endtask
    task expect_grant(input mipc_pkg::mipc_src_t s, input logic [15:0] v);
        for (int n = 0; n < 60 && gq.size() == 0; n++) begin
            @(posedge clk);
            #2;
        end
        `CHK("grant", {1'b1, s, v}, (gq.size() != 0) ? gq.pop_front() : 20'h0_0000);
    endtask
    task no_grant(input int n);
        gq.delete();
        repeat (n) @(posedge clk);
        #2 `CHK("no grant", 0, gq.size());
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task sc_reset;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        expect_grant(mipc_pkg::MIPC_SRC_RESET, `MIPC_VEC_RESET);
        `CHK("mask", 1'b1, mask_q);
        rd_chk(8'h0C, 8'h10);
        rd_chk(8'h12, 8'h00);
        rd_chk(8'h15, 8'h00);
    endtask
    task sc_protect;
        pulse(0);
        wr(8'h0C, 8'h70);
        rd_chk(8'h0C, 8'h10);
        pulse(1);
        wr(8'h0C, 8'h30);
        rd_chk(8'h0C, 8'h30);
    endtask
    task sc_priority;
        mipc_pkg::mipc_src_t s [4];
        logic [15:0]         v [4];
        logic [4:0]          m [4];
        s = '{mipc_pkg::MIPC_SRC_CAPT, mipc_pkg::MIPC_SRC_CMP, mipc_pkg::MIPC_SRC_OVF, mipc_pkg::MIPC_SRC_SER};
        v = '{`MIPC_VEC_CAPT, `MIPC_VEC_CMP, `MIPC_VEC_OVF, `MIPC_VEC_SER};
        m = '{5'h18, 5'h06, 5'h01, 5'h00};
        @(posedge clk);
        {tmr_flags, ser_flags} <= {5'h1F, 5'h10};
        pulse(0);
        no_grant(12);
        pulse(1);
        wr(8'h12, 8'hE0);
        wr(8'h0F, 8'hF0);
        rd_chk(8'h13, 8'hF8);
        rd_chk(8'h10, 8'h80);
        no_grant(12);
        for (int i = 0; i < 4; i++) begin
            pulse(0);
            expect_grant(s[i], v[i]);
            @(posedge clk);
            tmr_flags <= tmr_flags & ~m[i];
        end
        ser_flags <= 5'h00;
    endtask
    task sc_trap;
        pulse(2);
        expect_grant(mipc_pkg::MIPC_SRC_TRAP, `MIPC_VEC_TRAP);
        @(posedge clk);
        {mask_clr, tmr_flags} <= {1'b1, 5'h01};
        @(posedge clk);
        {mask_clr, trap_fetch} <= 2'b01;
        @(posedge clk);
        trap_fetch <= 1'b0;
        expect_grant(mipc_pkg::MIPC_SRC_OVF, `MIPC_VEC_OVF);
        tmr_flags <= 5'h00;
        expect_grant(mipc_pkg::MIPC_SRC_TRAP, `MIPC_VEC_TRAP);
    endtask
    task sc_ext;
        slow <= 1'b1;
        pulse(0);
        @(posedge clk);
        ext_pin <= 1'b0;
        expect_grant(mipc_pkg::MIPC_SRC_EXT, `MIPC_VEC_EXT);
        `CHK("mask", 1'b1, mask_q);
        @(posedge clk);
        ext_pin <= 1'b1;
        pulse(0);
        no_grant(12);
    endtask
    task sc_latch;
        pulse(1);
        wr(8'h0C, 8'h20);
        pulse(0);
        @(posedge clk);
        ext_pin <= 1'b0;
        no_grant(12);
        @(posedge clk);
        ext_pin <= 1'b1;
        pulse(1);
        wr(8'h0C, 8'h30);
        pulse(0);
        expect_grant(mipc_pkg::MIPC_SRC_EXT, `MIPC_VEC_EXT);
        @(posedge clk);
        ext_pin <= 1'b0;
        repeat (6) @(posedge clk);
        wr(8'h0C, 8'h50);
        pulse(0);
        no_grant(12);
        @(posedge clk);
        ext_pin <= 1'b1;
        expect_grant(mipc_pkg::MIPC_SRC_EXT, `MIPC_VEC_EXT);
    endtask
    task sc_sleep;
        pulse(3);
        repeat (2) @(posedge clk);
        #2 `CHK("cpu clk", {1'b0, 1'b1}, {cpu_clk_run, osc_run});
        @(posedge clk);
        tmr_flags <= 5'h01;
        expect_grant(mipc_pkg::MIPC_SRC_OVF, `MIPC_VEC_OVF);
        `CHK("cpu clk", 1'b1, cpu_clk_run);
        @(posedge clk);
        tmr_flags <= 5'h00;
        pulse(4);
        @(posedge clk);
        tmr_flags <= 5'h01;
        no_grant(10);
        `CHK("osc", 1'b0, osc_run);
        @(posedge clk);
        {tmr_flags, ext_pin} <= {5'h00, 1'b0};
        repeat (4) @(posedge clk);
        ext_pin <= 1'b1;
        expect_grant(mipc_pkg::MIPC_SRC_EXT, `MIPC_VEC_EXT);
        `CHK("osc", 1'b1, osc_run);
    endtask

    initial begin
        sc_reset();
        sc_protect();
        sc_priority();
        sc_trap();
        sc_ext();
        sc_latch();
        sc_sleep();
        results();
    end
endmodule
